// [hw/axis_gating_consts.svh]
// Purpose: offsets, field positions, reset values and widths of the manual input gating block
// Assumes: included by the package only
// Notes:   all register offsets are byte addresses on a 32-bit APB bus
`ifndef AXIS_GATING_CONSTS_SVH
`define AXIS_GATING_CONSTS_SVH

`define DEFL_W          16
`define NUM_AXES        4
`define DIR_W           3
`define CODE_W          8

`define OFS_GLOBAL_EN   12'h000
`define OFS_AXIS_DIR    12'h004
`define OFS_AXIS_ONE    12'h008
`define OFS_SWAP        12'h00c
`define OFS_AUTOSTATUS  12'h010
`define OFS_IRQ_STATUS  12'h014
`define OFS_IRQ_MASK    12'h018

`define GEN_OFF         3'h0
`define GEN_MAX         3'h5
`define GEN_RESET       3'h2
`define GEN_QUIET_OFF   8'hff
`define DIR_RESET_LOW   3'h2
`define DIR_RESET_HIGH  3'h0
`define AUTOSTATUS_RST  1'h1

`define AXDIR_SEL_LSB   8
`define AXDIR_SEL_W     2
`define AXDIR_ALL_BIT   11

`define EVT_REPLY       0
`define EVT_REJECT      1
`define NUM_EVT         2

`endif

// [hw/axis_gating_pkg.sv]
// Purpose: shared types of the manual input gating block
// Assumes: constants come from the guarded header
// Notes:   deflections are two's complement, zero at stick centre
package axis_gating_pkg;
  `include "axis_gating_consts.svh"

  typedef logic signed [`DEFL_W-1:0] defl_t;
  typedef logic signed [`DIR_W-1:0]  dir_t;

  typedef struct packed {
    defl_t x;
    defl_t y;
    defl_t z;
  } stick_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } apb_req_t;
endpackage

// [hw/irq_bank.sv]
// Purpose: sticky event flags with write-one-to-clear, a mask and one level interrupt
// Assumes: single clock, events are one-cycle pulses
// Notes:   a new event in the clearing cycle keeps its flag set
`timescale 1ns/1ns
`default_nettype none
module irq_bank #(
  parameter int N = 2
) (
  input  wire logic         clk,      // controller clock
  input  wire logic         rstn,     // async reset, active low
  input  wire logic [N-1:0] event_in, // one-cycle event pulses
  input  wire logic [N-1:0] clr,      // one-cycle write-one-to-clear
  input  wire logic [N-1:0] mask_in,  // enable bits
  output logic      [N-1:0] status,   // sticky flags
  output logic              irq       // level, high while an enabled flag is set
);
  logic [N-1:0] next_status;

  // set wins over clear so an event is never lost
  always_comb begin
    next_status = (status & ~clr) | event_in;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  assign irq = |(status & mask_in);
endmodule
`default_nettype wire

// [hw/axis_route.sv]
// Purpose: gates and orients one stick deflection onto one motor axis
// Assumes: deflection already chosen for this axis
// Notes:   the most negative deflection saturates when reversed
`timescale 1ns/1ns
`default_nettype none
module axis_route
  import axis_gating_pkg::*;
(
  input  wire logic  clk,       // controller clock
  input  wire logic  rstn,      // async reset, active low
  input  wire defl_t defl,      // deflection routed to this axis
  input  wire dir_t  dir,       // stored per-axis code
  input  wire logic  global_on, // global enable is on
  output defl_t      vel,       // velocity demand from manual input
  output logic       manual_on, // axis follows manual input
  output logic       speed_en   // continuous velocity move allowed
);
  defl_t next_vel;
  logic  next_manual_on;
  logic  next_speed_en;

  // zero code ignores deflection, negative code reverses it
  always_comb begin
    next_manual_on = global_on && (dir != '0);
    next_speed_en  = global_on && (dir != '0);
    next_vel       = '0;
    if (next_manual_on) begin
      if (dir[`DIR_W-1]) begin
        next_vel = (defl == {1'b1, {(`DEFL_W-1){1'b0}}}) ? {1'b0, {(`DEFL_W-1){1'b1}}}
                                                         : -defl;
      end else begin
        next_vel = defl;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vel       <= '0;
      manual_on <= 1'b0;
      speed_en  <= 1'b0;
    end else begin
      vel       <= next_vel;
      manual_on <= next_manual_on;
      speed_en  <= next_speed_en;
    end
  end
endmodule
`default_nettype wire

// [hw/manual_input_axis_gating.sv]
// Purpose: APB command block for global enable, per-axis direction and X/Y swap of manual input
// Assumes: one 250 MHz clock, zero-wait APB, stick inputs synchronous to clk
// Notes:   set forms are register writes, query forms are register reads
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module manual_input_axis_gating
  import axis_gating_pkg::*;
(
  input  wire logic                  clk,            // 250 MHz controller clock
  input  wire logic                  rstn,           // async reset, active low
  input  wire logic                  psel,           // apb select
  input  wire logic                  penable,        // apb access phase
  input  wire logic                  pwrite,         // apb direction
  input  wire logic [11:0]           paddr,          // apb byte address
  input  wire logic [31:0]           pwdata,         // apb write data
  output logic      [31:0]           prdata,         // apb read data, registered
  output logic                       pready,         // apb ready, always high
  output logic                       pslverr,        // apb error
  input  wire stick_t                stick,          // raw deflections
  input  wire logic                  device_is_stick,// attached device is a stick
  output defl_t                      axis_vel [`NUM_AXES], // manual velocity per axis
  output logic      [`NUM_AXES-1:0]  manual_on,      // axis follows manual input
  output logic      [`NUM_AXES-1:0]  speed_en,       // velocity move allowed per axis
  output logic                       global_on,      // manual input and velocity move on
  output logic                       status_reply,   // one-cycle unsolicited status reply
  output logic                       irq             // level interrupt
);
  apb_req_t                req;
  logic                    wr_acc;
  logic                    rd_setup;
  logic                    mapped;
  logic signed [`CODE_W-1:0] code;
  logic [2:0]              gen_state;
  logic [2:0]              next_gen_state;
  dir_t                    dir [`NUM_AXES];
  dir_t                    next_dir [`NUM_AXES];
  logic [`AXDIR_SEL_W-1:0] one_sel;
  logic [`AXDIR_SEL_W-1:0] next_one_sel;
  logic                    swap;
  logic                    next_swap;
  logic                    autostatus;
  logic                    next_autostatus;
  logic [`NUM_EVT-1:0]     irq_mask;
  logic [`NUM_EVT-1:0]     next_irq_mask;
  logic [`NUM_EVT-1:0]     irq_status;
  logic [`NUM_EVT-1:0]     irq_clr;
  logic                    next_reply;
  logic                    reject;
  logic [31:0]             next_prdata;
  logic                    next_pslverr;
  logic                    dir_ok;
  logic                    bad_word;
  defl_t                   src [`NUM_AXES];
  defl_t                   sx;
  defl_t                   sy;

  assign req     = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign wr_acc  = psel && penable && req.write;
  assign rd_setup = psel && !penable && !req.write;
  assign code    = req.wdata[`CODE_W-1:0];
  assign pready  = 1'b1;
  assign global_on = (gen_state != `GEN_OFF);

  // address decode used only by the error path, for reads and writes
  always_comb begin
    case (req.addr)
      `OFS_GLOBAL_EN, `OFS_AXIS_DIR, `OFS_AXIS_ONE, `OFS_SWAP,
      `OFS_AUTOSTATUS, `OFS_IRQ_STATUS, `OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // per-axis codes allowed: -2, -1, 0, 1, 2
  always_comb begin
    dir_ok = (code >= -8'sd2) && (code <= 8'sd2);
  end

  // parameter check from the setup cycle, so a registered error stands in the access cycle
  always_comb begin
    case (req.addr)
      `OFS_GLOBAL_EN: bad_word = !((code == `GEN_QUIET_OFF) || (code >= 8'sd0 && code <= 8'sd5));
      `OFS_AXIS_DIR:  bad_word = !dir_ok;
      `OFS_SWAP:      bad_word = (req.wdata[31:1] != '0);
      default:        bad_word = 1'b0;
    endcase
  end

  // command state: writes take effect in the access cycle only
  always_comb begin
    next_gen_state  = gen_state;
    next_dir        = dir;
    next_one_sel    = one_sel;
    next_swap       = swap;
    next_autostatus = autostatus;
    next_irq_mask   = irq_mask;
    next_reply      = 1'b0;
    reject          = 1'b0;
    irq_clr         = '0;
    if (wr_acc) begin
      case (req.addr)
        `OFS_GLOBAL_EN: begin
          if (code == `GEN_QUIET_OFF) begin
            next_gen_state = `GEN_OFF;
          end else if (code >= 8'sd0 && code <= 8'sd5) begin
            next_gen_state = code[2:0];
            // only an on-to-off change with autostatus speaks up
            next_reply = (code == 8'sd0) && global_on && autostatus;
          end else begin
            reject = 1'b1;
          end
        end
        `OFS_AXIS_DIR: begin
          if (!dir_ok) begin
            reject = 1'b1;
          end else begin
            for (int i = 0; i < `NUM_AXES; i++) begin
              if (req.wdata[`AXDIR_ALL_BIT] ||
                  (req.wdata[`AXDIR_SEL_LSB +: `AXDIR_SEL_W] == i[`AXDIR_SEL_W-1:0])) begin
                next_dir[i] = code[`DIR_W-1:0];
              end
            end
          end
        end
        `OFS_AXIS_ONE: next_one_sel = req.wdata[`AXDIR_SEL_W-1:0];
        `OFS_SWAP: begin
          if (req.wdata[31:1] != '0) begin
            reject = 1'b1;
          end else begin
            next_swap = req.wdata[0];
          end
        end
        `OFS_AUTOSTATUS: next_autostatus = req.wdata[0];
        `OFS_IRQ_STATUS: irq_clr = req.wdata[`NUM_EVT-1:0];
        `OFS_IRQ_MASK:   next_irq_mask = req.wdata[`NUM_EVT-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gen_state  <= `GEN_RESET;
      for (int i = 0; i < `NUM_AXES; i++) begin
        dir[i] <= (i == `NUM_AXES-1) ? `DIR_RESET_HIGH : `DIR_RESET_LOW;
      end
      one_sel      <= '0;
      swap         <= 1'b0;
      autostatus   <= `AUTOSTATUS_RST;
      irq_mask     <= '0;
      status_reply <= 1'b0;
    end else begin
      gen_state    <= next_gen_state;
      dir          <= next_dir;
      one_sel      <= next_one_sel;
      swap         <= next_swap;
      autostatus   <= next_autostatus;
      irq_mask     <= next_irq_mask;
      status_reply <= next_reply;
    end
  end

  // read data is captured in the setup cycle, so the access cycle needs no wait
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (rd_setup) begin
      next_prdata = '0;
      case (req.addr)
        `OFS_GLOBAL_EN:  next_prdata[2:0] = gen_state;
        `OFS_AXIS_DIR: begin
          for (int i = 0; i < `NUM_AXES; i++) begin
            next_prdata[i*8 +: 8] = {{(8-`DIR_W){dir[i][`DIR_W-1]}}, dir[i]};
          end
        end
        `OFS_AXIS_ONE: begin
          next_prdata[7:0] = {{(8-`DIR_W){dir[one_sel][`DIR_W-1]}}, dir[one_sel]};
          next_prdata[`AXDIR_SEL_LSB +: `AXDIR_SEL_W] = one_sel;
        end
        `OFS_SWAP:       next_prdata[0] = swap;
        `OFS_AUTOSTATUS: next_prdata[0] = autostatus;
        `OFS_IRQ_STATUS: next_prdata[`NUM_EVT-1:0] = irq_status;
        `OFS_IRQ_MASK:   next_prdata[`NUM_EVT-1:0] = irq_mask;
        default: ;
      endcase
    end
    if (psel && !penable) begin
      next_pslverr = !mapped || (req.write && bad_word);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // the refusal event is registered so its flag rises after the refused access
  logic reject_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reject_q <= 1'b0;
    end else begin
      reject_q <= reject;
    end
  end

  irq_bank #(.N(`NUM_EVT)) u_irq (
    .clk      (clk),
    .rstn     (rstn),
    .event_in ({reject_q, status_reply}),
    .clr      (irq_clr),
    .mask_in  (irq_mask),
    .status   (irq_status),
    .irq      (irq)
  );

  // swap only exists for sticks; other devices keep their own axes
  always_comb begin
    sx = (swap && device_is_stick) ? stick.y : stick.x;
    sy = (swap && device_is_stick) ? stick.x : stick.y;
    src[0] = sx;
    src[1] = sy;
    src[2] = stick.z;
    src[3] = stick.z;
  end

  for (genvar g = 0; g < `NUM_AXES; g++) begin : g_axis
    axis_route u_route (
      .clk       (clk),
      .rstn      (rstn),
      .defl      (src[g]),
      .dir       (dir[g]),
      .global_on (global_on),
      .vel       (axis_vel[g]),
      .manual_on (manual_on[g]),
      .speed_en  (speed_en[g])
    );
  end

  // checks next to the logic they guard
  property p_off_gates_all;
    @(posedge clk) disable iff (!rstn)
    (gen_state == `GEN_OFF) [*2] |-> (manual_on == '0) && (speed_en == '0);
  endproperty
  a_off_gates_all: assert property (p_off_gates_all) else $error("axis active while off");

  property p_quiet_off;
    @(posedge clk) disable iff (!rstn)
    (wr_acc && req.addr == `OFS_GLOBAL_EN && code == -8'sd1)
      |=> (gen_state == `GEN_OFF) && !status_reply;
  endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("quiet disable failed");

  property p_reply_on_off;
    @(posedge clk) disable iff (!rstn)
    (wr_acc && req.addr == `OFS_GLOBAL_EN && code == 8'sd0 && global_on && autostatus)
      |=> status_reply ##1 !status_reply;
  endproperty
  a_reply_on_off: assert property (p_reply_on_off) else $error("missing status reply");

  property p_reply_cause;
    @(posedge clk) disable iff (!rstn)
    status_reply |-> $past(wr_acc && req.addr == `OFS_GLOBAL_EN && code == 8'sd0
                           && gen_state != `GEN_OFF && autostatus);
  endproperty
  a_reply_cause: assert property (p_reply_cause) else $error("unexpected status reply");

  property p_one_is_on;
    @(posedge clk) disable iff (!rstn)
    (wr_acc && req.addr == `OFS_GLOBAL_EN && code == 8'sd1) |=> global_on && gen_state == 3'h1;
  endproperty
  a_one_is_on: assert property (p_one_is_on) else $error("value 1 did not enable");

  property p_reject_keeps;
    @(posedge clk) disable iff (!rstn)
    (wr_acc && req.addr == `OFS_GLOBAL_EN && (code > 8'sd5 || code < -8'sd1))
      |=> $stable(gen_state) ##1 $stable(gen_state) && irq_status[`EVT_REJECT];
  endproperty
  a_reject_keeps: assert property (p_reject_keeps) else $error("bad value not rejected");

  property p_swap_routes;
    @(posedge clk) disable iff (!rstn)
    (swap && device_is_stick && global_on && dir[0] == 3'sd2) |=> axis_vel[0] == $past(stick.y);
  endproperty
  a_swap_routes: assert property (p_swap_routes) else $error("swap not applied");

  property p_no_swap_other;
    @(posedge clk) disable iff (!rstn)
    (!device_is_stick && global_on && dir[1] == 3'sd2) |=> axis_vel[1] == $past(stick.y);
  endproperty
  a_no_swap_other: assert property (p_no_swap_other) else $error("swap on non-stick");

  property p_speed_gate;
    @(posedge clk) disable iff (!rstn)
    ##1 speed_en[3] == $past(global_on && dir[3] != '0);
  endproperty
  a_speed_gate: assert property (p_speed_gate) else $error("speed gate wrong");

  property p_query_gen;
    @(posedge clk) disable iff (!rstn)
    (rd_setup && req.addr == `OFS_GLOBAL_EN)
      |=> prdata[2:0] == $past(gen_state) && prdata[2:0] <= `GEN_MAX;
  endproperty
  a_query_gen: assert property (p_query_gen) else $error("enable query wrong");

  c_reply:   cover property (@(posedge clk) disable iff (!rstn) status_reply);
  c_swap:    cover property (@(posedge clk) disable iff (!rstn)
                             swap && device_is_stick && global_on);
  c_axis4:   cover property (@(posedge clk) disable iff (!rstn) manual_on[3] && !manual_on[2]);
  c_reject:  cover property (@(posedge clk) disable iff (!rstn) reject);
endmodule
`default_nettype wire

// [verification/host_apb.sv]
// Purpose: host model issuing set and query words to the gating block over APB
// Assumes: the bench calls xfer through this instance, one transfer at a time
// Notes:   a transfer that never sees pready raises hung instead of waiting forever
`timescale 1ns/1ns
`default_nettype none
module host_apb (
  input  wire logic        clk,     // controller clock
  output logic             psel,    // select
  output logic             penable, // access phase
  output logic             pwrite,  // direction
  output logic [11:0]      paddr,   // byte address
  output logic [31:0]      pwdata,  // write data
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready,  // ready
  input  wire logic        pslverr  // error
);
  logic        hung; // last transfer ran out of time
  logic [31:0] rd;   // read data of last transfer
  logic        err;  // error flag of last transfer
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // setup, then access held until pready is sampled high at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    hung = (pready !== 1'b1);
    rd   = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // silent disable: automatic status is off around the enable write
  task automatic quiet_off();
    xfer(1'b1, 12'h010, 32'h0);
    xfer(1'b1, 12'h000, 32'h0);
    xfer(1'b1, 12'h010, 32'h1);
  endtask
endmodule
`default_nettype wire

// [verification/test_manual_input_axis_gating.sv]
// Purpose: self-checking bench of the manual input gating block
// Assumes: host model drives APB, the bench drives stick and reset
// Notes:   ordinary writes run from a table, routing, irq and reset by hand
`timescale 1ns/1ns
`default_nettype none
module test_manual_input_axis_gating;
  import axis_gating_pkg::*;
  typedef struct packed {
    logic [11:0] a; // register
    logic [31:0] d; // word written
    logic        e; // refusal expected
    logic [31:0] r; // word read back
    logic        p; // reply pulse expected
    logic [3:0]  m; // axes following manual input
    logic        g; // global enable on
  } row_t;
  localparam int NR = 26;
  localparam row_t ROWS [NR] = '{
    '{12'h000, 32'h1, 1'b0, 32'h1, 1'b0, 4'h7, 1'b1},
    '{12'h000, 32'h0, 1'b0, 32'h0, 1'b1, 4'h0, 1'b0},
    '{12'h000, 32'h0, 1'b0, 32'h0, 1'b0, 4'h0, 1'b0},
    '{12'h000, 32'h5, 1'b0, 32'h5, 1'b0, 4'h7, 1'b1},
    '{12'h000, 32'h3, 1'b0, 32'h3, 1'b0, 4'h7, 1'b1},
    '{12'h000, 32'h4, 1'b0, 32'h4, 1'b0, 4'h7, 1'b1},
    '{12'h000, 32'hff, 1'b0, 32'h0, 1'b0, 4'h0, 1'b0},
    '{12'h000, 32'h6, 1'b1, 32'h0, 1'b0, 4'h0, 1'b0},
    '{12'h000, 32'h2, 1'b0, 32'h2, 1'b0, 4'h7, 1'b1},
    '{12'h004, 32'h0fe, 1'b0, 32'h000202fe, 1'b0, 4'h7, 1'b1},
    '{12'h004, 32'h001, 1'b0, 32'h00020201, 1'b0, 4'h7, 1'b1},
    '{12'h004, 32'h0ff, 1'b0, 32'h000202ff, 1'b0, 4'h7, 1'b1},
    '{12'h004, 32'h302, 1'b0, 32'h020202ff, 1'b0, 4'hf, 1'b1},
    '{12'h004, 32'h200, 1'b0, 32'h020002ff, 1'b0, 4'hb, 1'b1},
    '{12'h004, 32'h003, 1'b1, 32'h020002ff, 1'b0, 4'hb, 1'b1},
    '{12'h004, 32'h800, 1'b0, 32'h0, 1'b0, 4'h0, 1'b1},
    '{12'h004, 32'h802, 1'b0, 32'h02020202, 1'b0, 4'hf, 1'b1},
    '{12'h004, 32'h300, 1'b0, 32'h00020202, 1'b0, 4'h7, 1'b1},
    '{12'h00c, 32'h1, 1'b0, 32'h1, 1'b0, 4'h7, 1'b1},
    '{12'h00c, 32'h2, 1'b1, 32'h1, 1'b0, 4'h7, 1'b1},
    '{12'h010, 32'h0, 1'b0, 32'h0, 1'b0, 4'h7, 1'b1},
    '{12'h000, 32'h0, 1'b0, 32'h0, 1'b0, 4'h0, 1'b0},
    '{12'h010, 32'h1, 1'b0, 32'h1, 1'b0, 4'h0, 1'b0},
    '{12'h000, 32'h2, 1'b0, 32'h2, 1'b0, 4'h7, 1'b1},
    '{12'h01c, 32'h5, 1'b1, 32'h0, 1'b0, 4'h7, 1'b1},
    '{12'h008, 32'h1, 1'b0, 32'h102, 1'b0, 4'h7, 1'b1}
  };
  logic                 clk;          // 250 MHz clock
  logic                 rstn;         // reset, active low
  stick_t               stick;        // stick deflections
  logic                 is_stick;     // attached device is a stick
  wire                  psel;         // apb select
  wire                  penable;      // apb access
  wire                  pwrite;       // apb direction
  wire [11:0]           paddr;        // apb address
  wire [31:0]           pwdata;       // apb write data
  wire [31:0]           prdata;       // apb read data
  wire                  pready;       // apb ready
  wire                  pslverr;      // apb error
  defl_t                axis_vel [`NUM_AXES]; // manual velocity
  logic [`NUM_AXES-1:0] manual_on;    // axes following the stick
  logic [`NUM_AXES-1:0] speed_en;     // velocity moves allowed
  logic                 global_on;    // global enable
  logic                 status_reply; // reply pulse
  logic                 irq;          // interrupt
  int                   error_cnt = 0;
  int                   tests_run = 0;
  int                   replies = 0;  // reply pulses counted
  int                   n0;

  host_apb host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  manual_input_axis_gating dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stick(stick), .device_is_stick(is_stick), .axis_vel(axis_vel),
    .manual_on(manual_on), .speed_en(speed_en), .global_on(global_on),
    .status_reply(status_reply), .irq(irq));

  // clock free-runs from time zero
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // a pulse lasts one cycle, so counting at edges sees each one once
  always @(posedge clk) begin
    if (status_reply === 1'b1)
      replies <= replies + 1;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // a hung bus ends the run rather than stalling it
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    host.xfer(w, a, d);
    if (host.hung) begin
      error_cnt++;
      stop_test();
    end
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
  endtask

  initial begin
    rstn = 1'b0;
    is_stick = 1'b1;
    stick = '{x: 16'h0064, y: 16'h00c8, z: 16'h012c};
    do_reset();
    for (int i = 0; i < NR; i++) begin
      n0 = replies;
      bus(1'b1, ROWS[i].a, ROWS[i].d);
      chk("error", 32'(ROWS[i].e), 32'(host.err));
      bus(1'b0, ROWS[i].a, 32'h0);
      chk("read", ROWS[i].r, host.rd);
      chk("reply", 32'(ROWS[i].p), 32'(replies - n0));
      chk("manual_on", 32'(ROWS[i].m), 32'(manual_on));
      chk("speed_en", 32'(ROWS[i].m), 32'(speed_en));
      chk("global_on", 32'(ROWS[i].g), 32'(global_on));
      $display("row %0d done", i);
    end
    // swap is on, axis three has code 2, axis four has code 0
    chk("vel0", 32'h00c8, 32'(axis_vel[0]));
    chk("vel1", 32'h0064, 32'(axis_vel[1]));
    chk("vel3", 32'h0, 32'(axis_vel[3]));
    is_stick <= 1'b0;
    bus(1'b1, 12'h004, 32'h0fe);
    repeat (2) @(posedge clk); // new code reaches the registered velocity one edge after the access edge
    chk("vel0", 32'hffffff9c, 32'(axis_vel[0]));
    chk("vel2", 32'h012c, 32'(axis_vel[2]));
    $display("routing done");
    // both event flags are pending from the table, mask still clear
    bus(1'b0, 12'h014, 32'h0);
    chk("irq_status", 32'h3, host.rd);
    chk("irq", 32'h0, 32'(irq));
    bus(1'b1, 12'h018, 32'h3);
    @(posedge clk); // the mask register updates at the access edge itself
    chk("irq", 32'h1, 32'(irq));
    bus(1'b1, 12'h014, 32'h1);
    bus(1'b0, 12'h014, 32'h0);
    chk("irq_status", 32'h2, host.rd);
    bus(1'b1, 12'h014, 32'h2);
    @(posedge clk); // the clear lands at the access edge itself
    chk("irq", 32'h0, 32'(irq));
    $display("interrupt done");
    n0 = replies;
    host.quiet_off();
    chk("quiet_reply", 32'h0, 32'(replies - n0));
    chk("global_on", 32'h0, 32'(global_on));
    $display("quiet disable done");
    // a second reset mid-run must restore the enable, direction, swap and manual_on defaults
    do_reset();
    bus(1'b0, 12'h000, 32'h0);
    chk("gen_rst", 32'h2, host.rd);
    bus(1'b0, 12'h004, 32'h0);
    chk("dir_rst", 32'h00020202, host.rd);
    bus(1'b0, 12'h00c, 32'h0);
    chk("swap_rst", 32'h0, host.rd);
    chk("manual_rst", 32'h7, 32'(manual_on));
    $display("reset done");
    stop_test();
  end
endmodule
`default_nettype wire
